// ### hw/pcr_pkg.sv
package pcr_pkg;
	// =========================================
	// Register offsets (byte addresses)
	localparam int unsigned ADDR_W = 4;
	localparam logic [3:0] OFS_MODES = 4'h0;
	localparam logic [3:0] OFS_CHECK = 4'h4;
	localparam logic [3:0] OFS_CACHE = 4'h8;
	localparam logic [3:0] OFS_WAYS  = 4'hC;
	// =========================================
	// Issue mode field positions
	localparam int unsigned MB_PREDICT = 20;
	localparam int unsigned MB_TBSTOP  = 19;
	localparam int unsigned MB_DIAG    = 18;
	localparam int unsigned MB_OVERLAP = 17;
	localparam int unsigned MB_MULTI   = 16;
	// =========================================
	// Machine check field positions
	localparam int unsigned CK_WARM  = 25;
	localparam int unsigned CK_HOT   = 24;
	localparam int unsigned CK_RTYPE = 23;
	localparam int unsigned CK_FETCH = 22;
	localparam int unsigned CK_TAG   = 20;
	localparam int unsigned CK_BUSC  = 19;
	localparam int unsigned CK_PAR   = 18;
	localparam int unsigned CK_XLATE = 17;
	localparam int unsigned CK_SOFT  = 16;
	// =========================================
	// Cache and bus control field positions
	localparam int unsigned CC_RATIO_LO = 16;
	localparam int unsigned RATIO_W     = 5;
	localparam int unsigned CC_BC  = 15;
	localparam int unsigned CC_BS  = 14;
	localparam int unsigned CC_BE  = 13;
	localparam int unsigned CC_BT  = 12;
	localparam int unsigned CC_SB  = 11;
	localparam int unsigned CC_IE  = 10;
	localparam int unsigned CC_DE  = 9;
	localparam int unsigned CC_L2E = 8;
	localparam int unsigned CC_IP  = 4;
	localparam int unsigned CC_DP  = 3;
	localparam int unsigned CC_CM  = 2;
	localparam int unsigned CC_TM  = 1;
	localparam int unsigned CC_IC  = 0;
	localparam int unsigned WAY_LO = 24;
	localparam int unsigned WAYS   = 8;
	// =========================================
	// Writable masks, reset values
	localparam logic [31:0] MODES_WMASK = 32'h001F_0000;
	localparam logic [31:0] CHECK_WMASK = 32'h005F_0000;
	localparam logic [31:0] CACHE_WMASK = 32'h0000_FF1F;
	localparam logic [31:0] WAYS_WMASK  = 32'hFF00_0000;
	localparam logic [31:0] MODES_RST   = 32'h0000_0000;
	localparam logic [31:0] CHECK_RST   = 32'h0000_0000;
	localparam logic [31:0] CACHE_RST   = 32'h0000_0000;
	localparam logic [31:0] WAYS_RST    = 32'h0000_0000;
	// =========================================
	// Counts
	localparam logic [1:0] TB_PRESCALE = 2'h3;
	localparam logic [1:0] CFG_SETTLE  = 2'h3;
	localparam logic [1:0] ISSUE_ONE   = 2'h1;
	localparam logic [1:0] ISSUE_MULTI = 2'h3;
	localparam logic [4:0] EVSEL_TIME  = 5'h00;
endpackage

// ### hw/processor_control_register_bank.sv
// Functional notes
// - Prediction bit clear: predict all branches not taken; set: use predictor.
// - Event select zero: time base steps every fourth bus clock unless stopped.
// - Diagnostic load/store run only when diagnostic access bit set; else illegal trap.
// - Overlap bit clear: issue only with empty pipeline.
// - Multi-issue bit clear: one instruction per cycle; set: up to three.
// - Enabled or unmaskable check raises machine check; vector if enabled, else checkstop.
// - Reset-type flag is one after hard reset, zero after soft; read-only.
// - Fetch check enable reports multiple fetch translation hits.
// - Tag state and bus controller checks gated by their enables; middle bit ignored.
// - Parity errors gated by enable; transfer-error and check pins always taken.
// - Translation check enable reports multiple TLB or data block hits.
// - Software check bit rising raises one check; handler clears it.
// - Clock ratio loads from pins at hard reset; software cannot change it.
// - Broadcast-off bit stops cache op broadcast and snoop, except block-zero kills.
// - Sync and ordering broadcasts when bits clear; sync completes locally when set.
// - TLB broadcast-off bit stops TLB broadcasts and completes TLB sync locally.
// - Strobe pin copies strobe bit; breakpoint may invert it one bus cycle.
// - Cache enables clear: bypass cache; level 2 off: misses go off-chip.
// - Prefetch enables allow level 2 to fetch extra blocks on misses.
// - Way-disable writes need column mask bit; tag mask bit gates valid updates.
// - Coherent-mode bit keeps instruction cache coherent with stores.
// - Way-disable register bit 31-n removes way n; eight bits at top of register.
// - Event select zero joins both time base halves into one 64-bit counter.
// - Valid data in a newly disabled way is lost.
`timescale 1ns/100ps
`default_nettype none
module processor_control_register_bank
	import pcr_pkg::*;
(
	input  wire logic                       clk,                 // Core clock
	input  wire logic                       rst_n,               // Hard reset
	input  wire logic                       soft_reset,          // Soft reset pulse
	input  wire logic [pcr_pkg::ADDR_W-1:0] bus_addr,            // Byte address
	input  wire logic [31:0]                bus_wdata,           // Write data
	input  wire logic                       bus_write,           // Write strobe
	input  wire logic                       bus_read,            // Read strobe
	output logic [31:0]                     bus_rdata,           // Read data
	input  wire logic [pcr_pkg::RATIO_W-1:0] clock_cfg_pins,     // Ratio pins
	input  wire logic                       temp_warm_pin,       // Warm sensor
	input  wire logic                       temp_over_pin,       // Hot sensor
	input  wire logic                       transfer_error_n,    // Bus error pin
	input  wire logic                       check_request_n,     // Check pin
	input  wire logic                       bus_tick,            // One per bus clock
	input  wire logic [4:0]                 event_select,        // Event selector
	input  wire logic                       bp_hw_taken,         // Predictor guess
	output logic                            pred_taken,          // Used prediction
	input  wire logic                       diag_op,             // Diag access decoded
	output logic                            diag_exec,           // Diag access runs
	output logic                            diag_illegal,        // Illegal trap
	input  wire logic                       pipe_empty,          // Pipeline empty
	output logic                            issue_allow,         // Issue permitted
	output logic [1:0]                      issue_width_max,     // Issue limit
	input  wire logic                       err_fetch_multi,     // Fetch multi hit
	input  wire logic                       err_tag_state,       // Bad tag state
	input  wire logic                       err_bus_ctrl,        // Bad bus state
	input  wire logic                       err_parity,          // Bus parity error
	input  wire logic                       err_xlate_multi,     // Data multi hit
	input  wire logic                       check_intr_enable,   // State check enable
	output logic                            mc_vector,           // Take check vector
	output logic                            checkstop,           // Halted
	input  wire logic                       kill_req,            // Kill to send
	input  wire logic                       kill_block_zero,     // Kill from zeroing
	output logic                            kill_bcast,          // Kill goes out
	output logic                            snoop_enable,        // Snoop bus
	output logic                            cacheop_bcast,       // Send cache ops
	output logic                            sync_bcast,          // Send sync
	output logic                            sync_local,          // Sync done locally
	output logic                            ordering_bcast,      // Send ordering op
	output logic                            tlb_bcast,           // Send TLB ops
	output logic                            tlbsync_local,       // TLB sync local
	input  wire logic                       bkpt_strobe_inv,     // Breakpoint flip
	output logic                            strobe_pin,          // Strobe output
	output logic                            icache_enable,       // Icache on
	output logic                            dcache_enable,       // Dcache on
	output logic                            second_level_enable, // L2 on
	output logic                            fetch_prefetch_enable, // Fetch prefetch
	output logic                            data_prefetch_enable,  // Data prefetch
	output logic                            tag_valid_write_enable, // Valid writes
	output logic                            icache_coherent_mode,  // Coherent icache
	output logic [pcr_pkg::WAYS-1:0]        way_disable,         // Removed ways
	output logic [pcr_pkg::WAYS-1:0]        way_lost,            // Flush pulse
	output logic [63:0]                     timebase             // Time base
);
	import pcr_pkg::*;

	// =========================================
	// Pin synchronisers
	logic [RATIO_W-1:0] cfg_s1_reg, cfg_s2_reg;
	logic [3:0]         pin_s1_reg, pin_s2_reg;
	logic               tea_d_reg, mcp_d_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_s1_reg <= '0;
			cfg_s2_reg <= '0;
			pin_s1_reg <= 4'hC;
			pin_s2_reg <= 4'hC;
			tea_d_reg  <= 1'b1;
			mcp_d_reg  <= 1'b1;
		end else begin
			cfg_s1_reg <= clock_cfg_pins;
			cfg_s2_reg <= cfg_s1_reg;
			pin_s1_reg <= {transfer_error_n, check_request_n,
				temp_warm_pin, temp_over_pin};
			pin_s2_reg <= pin_s1_reg;
			tea_d_reg  <= pin_s2_reg[3];
			mcp_d_reg  <= pin_s2_reg[2];
		end
	end

	wire tea_fall = tea_d_reg & ~pin_s2_reg[3];
	wire mcp_fall = mcp_d_reg & ~pin_s2_reg[2];

	// =========================================
	// Register decode
	wire wr_modes = bus_write && (bus_addr == OFS_MODES);
	wire wr_check = bus_write && (bus_addr == OFS_CHECK);
	wire wr_cache = bus_write && (bus_addr == OFS_CACHE);
	wire wr_ways  = bus_write && (bus_addr == OFS_WAYS);

	logic [31:0]        modes_reg, check_reg, cache_reg, ways_reg;
	logic               rtype_reg;
	logic [RATIO_W-1:0] ratio_reg;
	logic [1:0]         cfg_cnt_reg;

	// Column mask bit guards the way register
	wire ways_we = wr_ways && cache_reg[CC_CM];
	wire [31:0] ways_new = bus_wdata & WAYS_WMASK;

	// Software check fires on the zero-to-one change only
	wire sw_rise = wr_check && bus_wdata[CK_SOFT] && !check_reg[CK_SOFT];

	// =========================================
	// Control registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			modes_reg <= MODES_RST;
			check_reg <= CHECK_RST;
			cache_reg <= CACHE_RST;
			rtype_reg <= 1'b1;
		end else if (soft_reset) begin
			modes_reg <= MODES_RST;
			check_reg <= CHECK_RST;
			cache_reg <= CACHE_RST;
			rtype_reg <= 1'b0;
		end else begin
			if (wr_modes)
				modes_reg <= bus_wdata & MODES_WMASK;
			if (wr_check)
				check_reg <= bus_wdata & CHECK_WMASK;
			if (wr_cache)
				cache_reg <= bus_wdata & CACHE_WMASK;
		end
	end

	// Ways survive soft reset: a self-test result must not be undone
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ways_reg <= WAYS_RST;
		else if (ways_we)
			ways_reg <= ways_new;
	end

	// Ratio follows the synced pins only for a few cycles after hard reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_cnt_reg <= '0;
			ratio_reg   <= '0;
		end else if (cfg_cnt_reg != CFG_SETTLE) begin
			cfg_cnt_reg <= cfg_cnt_reg + 2'h1;
			ratio_reg   <= cfg_s2_reg;
		end
	end

	// =========================================
	// Read path
	wire [31:0] check_view = check_reg
		| ({31'h0, pin_s2_reg[1]} << CK_WARM)
		| ({31'h0, pin_s2_reg[0]} << CK_HOT)
		| ({31'h0, rtype_reg} << CK_RTYPE);
	wire [31:0] cache_view = cache_reg
		| ({27'h0, ratio_reg} << CC_RATIO_LO);
	wire [31:0] rd_mux =
		(bus_addr == OFS_MODES) ? modes_reg :
		(bus_addr == OFS_CHECK) ? check_view :
		(bus_addr == OFS_CACHE) ? cache_view :
		(bus_addr == OFS_WAYS)  ? ways_reg : 32'h0000_0000;

	// =========================================
	// Machine check
	wire mc_hit =
		(err_fetch_multi & check_reg[CK_FETCH]) |
		(err_tag_state & check_reg[CK_TAG]) |
		(err_bus_ctrl & check_reg[CK_BUSC]) |
		(err_parity & check_reg[CK_PAR]) |
		tea_fall | mcp_fall |
		(err_xlate_multi & check_reg[CK_XLATE]) |
		sw_rise;

	// =========================================
	// Time base and strobe
	wire tb_run = (event_select == EVSEL_TIME) && !modes_reg[MB_TBSTOP];
	logic [1:0] tb_pre_reg;
	logic       inv_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tb_pre_reg <= '0;
			timebase   <= '0;
		end else if (tb_run && bus_tick) begin
			tb_pre_reg <= tb_pre_reg + 2'h1;
			if (tb_pre_reg == TB_PRESCALE)
				timebase <= timebase + 64'h1;
		end
	end

	// Flip stands until the next bus clock; a new flip wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			inv_reg <= 1'b0;
		else if (bkpt_strobe_inv)
			inv_reg <= 1'b1;
		else if (bus_tick)
			inv_reg <= 1'b0;
	end

	// Way n sits at register bit 31-n; the ports are indexed by way number
	function automatic logic [WAYS-1:0] way_order(input logic [31:0] regval);
		for (int n = 0; n < WAYS; n++)
			way_order[n] = regval[WAY_LO + WAYS - 1 - n];
	endfunction

	// =========================================
	// Output flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata       <= '0;
			pred_taken      <= 1'b0;
			diag_exec       <= 1'b0;
			diag_illegal    <= 1'b0;
			issue_allow     <= 1'b0;
			issue_width_max <= ISSUE_ONE;
			mc_vector       <= 1'b0;
			checkstop       <= 1'b0;
			kill_bcast      <= 1'b0;
			snoop_enable    <= 1'b0;
			cacheop_bcast   <= 1'b0;
			sync_bcast      <= 1'b0;
			sync_local      <= 1'b0;
			ordering_bcast  <= 1'b0;
			tlb_bcast       <= 1'b0;
			tlbsync_local   <= 1'b0;
			strobe_pin      <= 1'b0;
			icache_enable   <= 1'b0;
			dcache_enable   <= 1'b0;
			second_level_enable    <= 1'b0;
			fetch_prefetch_enable  <= 1'b0;
			data_prefetch_enable   <= 1'b0;
			tag_valid_write_enable <= 1'b0;
			icache_coherent_mode   <= 1'b0;
			way_disable     <= '0;
			way_lost        <= '0;
		end else begin
			bus_rdata    <= bus_read ? rd_mux : 32'h0000_0000;
			pred_taken   <= modes_reg[MB_PREDICT] & bp_hw_taken;
			diag_exec    <= diag_op & modes_reg[MB_DIAG];
			diag_illegal <= diag_op & ~modes_reg[MB_DIAG];
			issue_allow  <= modes_reg[MB_OVERLAP] | pipe_empty;
			issue_width_max <= modes_reg[MB_MULTI] ? ISSUE_MULTI : ISSUE_ONE;
			mc_vector    <= mc_hit & check_intr_enable;
			// Checkstop holds until hard reset, soft reset leaves it: the core has halted
			checkstop    <= checkstop | (mc_hit & ~check_intr_enable);
			kill_bcast   <= kill_req & (~cache_reg[CC_BC] | kill_block_zero);
			snoop_enable   <= ~cache_reg[CC_BC];
			cacheop_bcast  <= ~cache_reg[CC_BC];
			sync_bcast     <= ~cache_reg[CC_BS];
			sync_local     <= cache_reg[CC_BS];
			ordering_bcast <= ~cache_reg[CC_BE];
			tlb_bcast      <= ~cache_reg[CC_BT];
			tlbsync_local  <= cache_reg[CC_BT];
			strobe_pin     <= cache_reg[CC_SB] ^ inv_reg;
			icache_enable  <= cache_reg[CC_IE];
			dcache_enable  <= cache_reg[CC_DE];
			second_level_enable    <= cache_reg[CC_L2E];
			fetch_prefetch_enable  <= cache_reg[CC_IP];
			data_prefetch_enable   <= cache_reg[CC_DP];
			tag_valid_write_enable <= cache_reg[CC_TM];
			icache_coherent_mode   <= cache_reg[CC_IC];
			way_disable    <= way_order(ways_reg);
			way_lost <= ways_we ? (way_order(ways_new)
				& ~way_order(ways_reg)) : '0;
		end
	end

	// =========================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_predict_gate: assert property (
		pred_taken |-> $past(modes_reg[MB_PREDICT] && bp_hw_taken))
		else $error("prediction used while disabled");

	a_tb_hold: assert property (
		!tb_run |=> $stable(timebase))
		else $error("time base moved while stopped");

	a_diag_trap: assert property (
		diag_op && !modes_reg[MB_DIAG] |=> diag_illegal && !diag_exec)
		else $error("diagnostic access not trapped");

	a_overlap_wait: assert property (
		issue_allow |-> $past(pipe_empty || modes_reg[MB_OVERLAP]))
		else $error("issue with busy pipeline");

	a_issue_width: assert property (
		wr_modes && !soft_reset ##1 !wr_modes && !soft_reset
		|=> issue_width_max == ($past(bus_wdata[MB_MULTI], 2) ? ISSUE_MULTI : ISSUE_ONE))
		else $error("issue limit wrong after write");

	a_check_stop: assert property (
		mc_hit && !check_intr_enable |=> checkstop && !mc_vector)
		else $error("checkstop not entered");

	a_rtype_ro: assert property (
		!soft_reset |=> $stable(rtype_reg))
		else $error("reset type flag changed");

	a_fetch_check: assert property (
		err_fetch_multi && check_reg[CK_FETCH] && check_intr_enable |=> mc_vector)
		else $error("fetch check lost");

	a_pin_check: assert property (
		(tea_fall || mcp_fall) && check_intr_enable |=> mc_vector)
		else $error("pin check lost");

	a_soft_single: assert property (
		sw_rise ##1 (wr_check && bus_wdata[CK_SOFT]) |-> !sw_rise)
		else $error("repeat software check");

	a_ratio_fixed: assert property (
		cfg_cnt_reg == CFG_SETTLE |=> $stable(ratio_reg))
		else $error("clock ratio changed");

	a_way_guard: assert property (
		wr_ways && !cache_reg[CC_CM] |=> $stable(ways_reg))
		else $error("way write not blocked");

	a_strobe_copy: assert property (
		!inv_reg |=> strobe_pin == $past(cache_reg[CC_SB]))
		else $error("strobe pin mismatch");

	a_way_loss: assert property (
		ways_we |=> !(|(way_lost & way_disable)))
		else $error("lost way was already disabled");

	a_kill_zero: assert property (
		kill_req && kill_block_zero |=> kill_bcast)
		else $error("zeroing kill not sent");

	a_kill_hold: assert property (
		kill_req && !kill_block_zero && cache_reg[CC_BC] |=> !kill_bcast)
		else $error("kill sent while broadcast off");

	a_tb_step: assert property (
		tb_run && bus_tick && tb_pre_reg == TB_PRESCALE
		|=> timebase == $past(timebase) + 64'h1)
		else $error("time base missed a step");

	a_soft_rtype: assert property (
		soft_reset |=> !rtype_reg)
		else $error("reset type not cleared by soft reset");

	a_modes_resv: assert property (
		bus_read && bus_addr == OFS_MODES |=> (bus_rdata & ~MODES_WMASK) == 32'h0000_0000)
		else $error("reserved mode bits read set");
endmodule
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import pcr_pkg::*;
	// ========================================
	// Signals
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        soft_reset = 1'b0;
	logic [3:0]  bus_addr = 4'h0;
	logic [31:0] bus_wdata = 32'h0000_0000;
	logic        bus_write = 1'b0;
	logic        bus_read = 1'b0;
	logic [31:0] bus_rdata;
	logic [4:0]  err_vec = 5'h00;
	logic        xfer_err_n = 1'b1;
	logic        chk_req_n = 1'b1;
	logic        bus_tick = 1'b0;
	logic        bp_hw_taken = 1'b1;
	logic        diag_op = 1'b0;
	logic        pipe_empty = 1'b0;
	logic        intr_en = 1'b1;
	logic        kill_req = 1'b0;
	logic        kill_bz = 1'b0;
	logic        bkpt_inv = 1'b0;
	logic        pred_taken, diag_exec, diag_illegal, issue_allow, mc_vector, checkstop;
	logic        kill_bcast, snoop_enable, cacheop_bcast, sync_bcast, sync_local;
	logic        ordering_bcast, tlb_bcast, tlbsync_local, strobe_pin;
	logic        ic_en, dc_en, l2_en, fp_en, dp_en, tv_en, ic_coh;
	logic [1:0]  issue_width_max;
	logic [7:0]  way_disable, way_lost, lost_acc;
	logic [63:0] timebase, tb0;
	logic [4:0]  ev_sel = 5'h00;
	int          num_errors = 0;
	int          checks_done = 0;
	int          mc_cnt = 0;
	int          en_pos [5] = '{CK_FETCH, CK_TAG, CK_BUSC, CK_PAR, CK_XLATE};
	always #10 clk = ~clk;
	// Pulse outputs are gathered here so a test can look over a window
	always @(posedge clk) begin
		if (mc_vector === 1'b1)
			mc_cnt++;
		lost_acc |= way_lost;
	end
	processor_control_register_bank processor_control_register_bank_i (
		.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
		.bus_rdata(bus_rdata), .clock_cfg_pins(5'h15), .temp_warm_pin(1'b0),
		.temp_over_pin(1'b0), .transfer_error_n(xfer_err_n), .check_request_n(chk_req_n),
		.bus_tick(bus_tick), .event_select(ev_sel), .bp_hw_taken(bp_hw_taken),
		.pred_taken(pred_taken), .diag_op(diag_op), .diag_exec(diag_exec),
		.diag_illegal(diag_illegal), .pipe_empty(pipe_empty), .issue_allow(issue_allow),
		.issue_width_max(issue_width_max), .err_fetch_multi(err_vec[0]),
		.err_tag_state(err_vec[1]), .err_bus_ctrl(err_vec[2]), .err_parity(err_vec[3]),
		.err_xlate_multi(err_vec[4]), .check_intr_enable(intr_en), .mc_vector(mc_vector),
		.checkstop(checkstop), .kill_req(kill_req), .kill_block_zero(kill_bz),
		.kill_bcast(kill_bcast), .snoop_enable(snoop_enable), .cacheop_bcast(cacheop_bcast),
		.sync_bcast(sync_bcast), .sync_local(sync_local), .ordering_bcast(ordering_bcast),
		.tlb_bcast(tlb_bcast), .tlbsync_local(tlbsync_local), .bkpt_strobe_inv(bkpt_inv),
		.strobe_pin(strobe_pin), .icache_enable(ic_en), .dcache_enable(dc_en),
		.second_level_enable(l2_en), .fetch_prefetch_enable(fp_en),
		.data_prefetch_enable(dp_en), .tag_valid_write_enable(tv_en),
		.icache_coherent_mode(ic_coh), .way_disable(way_disable), .way_lost(way_lost),
		.timebase(timebase)
	);
	// ========================================
	// Tasks
	task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		bus_write <= 1'b1;
		bus_addr  <= a;
		bus_wdata <= v;
		@(posedge clk);
		bus_write <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		bus_read <= 1'b1;
		bus_addr <= a;
		@(posedge clk);
		bus_read <= 1'b0;
		#1;
		chk(name, exp, bus_rdata);
		@(posedge clk);
		#1;
		chk("rdata idle", 32'h0000_0000, bus_rdata);
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Diag request seen one edge later, answer stands the following cycle
	task automatic diag_try(input logic [1:0] exp);
		@(posedge clk);
		diag_op <= 1'b1;
		@(posedge clk);
		diag_op <= 1'b0;
		#1;
		chk("diag exec/illegal", exp, {diag_exec, diag_illegal});
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			bus_tick <= 1'b1;
			@(posedge clk);
			bus_tick <= 1'b0;
		end
		cycles(3);
	endtask
	// Pin is held low several cycles; only the falling edge may count
	task automatic pin_low(input bit which);
		@(posedge clk);
		if (which)
			chk_req_n <= 1'b0;
		else
			xfer_err_n <= 1'b0;
		cycles(3);
		chk_req_n  <= 1'b1;
		xfer_err_n <= 1'b1;
		cycles(6);
	endtask
	task automatic finish_test;
		if (num_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ========================================
	// Tests
	initial begin
		#(20 * 20000);
		num_errors++;
		finish_test;
	end
	initial begin
		cycles(5);
		rst_n <= 1'b1;
		cycles(6);
		rd_chk("modes reset", OFS_MODES, 32'h0000_0000);
		rd_chk("check reset", OFS_CHECK, 32'h0080_0000);
		rd_chk("cache ratio", OFS_CACHE, 32'h0015_0000);
		rd_chk("unmapped", 4'h2, 32'h0000_0000);
		chk("pred off", 1'b0, pred_taken);
		chk("issue one", 2'h1, issue_width_max);
		chk("no overlap", 1'b0, issue_allow);
		pipe_empty <= 1'b1;
		cycles(2);
		chk("pipe empty", 1'b1, issue_allow);
		pipe_empty <= 1'b0;
		diag_try(2'b01);
		tb0 = timebase;
		ticks(8);
		chk("timebase run", tb0 + 64'h2, timebase);
		ev_sel <= 5'h01;
		tb0 = timebase;
		ticks(8);
		chk("timebase other event", tb0, timebase);
		ev_sel <= 5'h00;
		wr(OFS_MODES, 32'hFFFF_FFFF);
		rd_chk("modes mask", OFS_MODES, 32'h001F_0000);
		chk("pred on", 1'b1, pred_taken);
		bp_hw_taken <= 1'b0;
		cycles(2);
		chk("pred follows", 1'b0, pred_taken);
		bp_hw_taken <= 1'b1;
		chk("issue three", 2'h3, issue_width_max);
		chk("overlap", 1'b1, issue_allow);
		diag_try(2'b10);
		tb0 = timebase;
		ticks(8);
		chk("timebase stop", tb0, timebase);
		wr(OFS_WAYS, 32'hFF00_0000);
		rd_chk("ways locked", OFS_WAYS, 32'h0000_0000);
		chk("bcast on", 7'b1110110, {snoop_enable, cacheop_bcast, sync_bcast, sync_local,
			ordering_bcast, tlb_bcast, tlbsync_local});
		kill_req <= 1'b1;
		cycles(3);
		chk("kill out", 1'b1, kill_bcast);
		wr(OFS_CACHE, 32'hFFFF_FFFF);
		rd_chk("cache mask", OFS_CACHE, 32'h0015_FF1F);
		chk("bcast off", 7'b0001001, {snoop_enable, cacheop_bcast, sync_bcast, sync_local,
			ordering_bcast, tlb_bcast, tlbsync_local});
		chk("kill held", 1'b0, kill_bcast);
		kill_bz <= 1'b1;
		cycles(3);
		chk("kill zero", 1'b1, kill_bcast);
		kill_req <= 1'b0;
		kill_bz  <= 1'b0;
		chk("enables", 7'h7F, {ic_en, dc_en, l2_en, fp_en, dp_en, tv_en, ic_coh});
		chk("strobe", 1'b1, strobe_pin);
		@(posedge clk);
		bkpt_inv <= 1'b1;
		@(posedge clk);
		bkpt_inv <= 1'b0;
		cycles(2);
		chk("strobe flip", 1'b0, strobe_pin);
		ticks(1);
		chk("strobe back", 1'b1, strobe_pin);
		lost_acc = 8'h00;
		wr(OFS_WAYS, 32'hC0FF_FFFF);
		cycles(3);
		rd_chk("ways", OFS_WAYS, 32'hC000_0000);
		chk("way map", 8'h03, way_disable);
		chk("way lost", 8'h03, lost_acc);
		wr(OFS_CHECK, 32'h0000_0000);
		rd_chk("rtype ro", OFS_CHECK, 32'h0080_0000);
		for (int i = 0; i < 5; i++) begin
			for (int e = 0; e < 2; e++) begin
				wr(OFS_CHECK, e ? (32'h1 << en_pos[i]) : 32'h0000_0000);
				mc_cnt = 0;
				@(posedge clk);
				err_vec <= 5'h01 << i;
				@(posedge clk);
				err_vec <= 5'h00;
				cycles(4);
				chk("err check", e, mc_cnt);
			end
		end
		wr(OFS_CHECK, 32'h0020_0000);
		rd_chk("reserved chk", OFS_CHECK, 32'h0080_0000);
		mc_cnt = 0;
		pin_low(1'b0);
		pin_low(1'b1);
		chk("pin checks", 2, mc_cnt);
		mc_cnt = 0;
		// Two writes back to back: only the first is a rising edge
		@(posedge clk);
		bus_write <= 1'b1;
		bus_addr  <= OFS_CHECK;
		bus_wdata <= 32'h0001_0000;
		repeat (2) @(posedge clk);
		bus_write <= 1'b0;
		cycles(4);
		chk("soft once", 1, mc_cnt);
		wr(OFS_CHECK, 32'h0000_0000);
		wr(OFS_CHECK, 32'h0001_0000);
		chk("soft again", 2, mc_cnt);
		intr_en <= 1'b0;
		pin_low(1'b0);
		chk("no vector", 2, mc_cnt);
		chk("checkstop", 1'b1, checkstop);
		@(posedge clk);
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
		cycles(3);
		rd_chk("soft rtype", OFS_CHECK, 32'h0000_0000);
		rd_chk("soft ratio", OFS_CACHE, 32'h0015_0000);
		rd_chk("ways kept", OFS_WAYS, 32'hC000_0000);
		// Hard reset in mid-run restores the reset type and clears the halt
		@(posedge clk);
		rst_n <= 1'b0;
		cycles(2);
		rst_n <= 1'b1;
		cycles(6);
		rd_chk("hard rtype", OFS_CHECK, 32'h0080_0000);
		chk("stop cleared", 1'b0, checkstop);
		rd_chk("hard ratio", OFS_CACHE, 32'h0015_0000);
		rd_chk("hard ways", OFS_WAYS, 32'h0000_0000);
		finish_test;
	end
endmodule
`default_nettype wire
